// [dac_gate_regs.svh]
// Register offsets, field positions, reset values and filter scaling
`ifndef DAC_GATE_REGS_SVH
`define DAC_GATE_REGS_SVH

// Register offsets (15-bit serial-port address)
`define REG_IRQ_ENABLE      15'h020
`define REG_IRQ_STATUS      15'h024
`define REG_TX_GATE         15'h03f
`define REG_UPSAMPLE        15'h110
`define REG_DATAPATH_CFG    15'h111
`define REG_CHECKER_CTRL    15'h14b
`define REG_CHECKER_CNT_I   15'h14c
`define REG_CHECKER_CNT_Q   15'h14d
`define REG_TEST_WORD_HIGH  15'h14e
`define REG_TEST_WORD_LOW   15'h14f
`define REG_CONST_CFG       15'h150
`define REG_HOP_CTRL        15'h800

// Field positions
`define ROLLOFF_EN_BIT      7
`define CONST_EN_BIT        1
`define CHK_EN_BIT          0
`define CHK_RST_BIT         1
`define CHK_SEL_BIT         2
`define CHK_PASS_I_BIT      6
`define CHK_PASS_Q_BIT      7
`define HOP_MODE_MSB        7
`define HOP_MODE_LSB        6
`define HOP_MODE_DISCONT    2'h1
`define UPSAMPLE_BYPASS     4'h0

// Reset values
`define TX_GATE_RESET       8'hc0
`define REG_ZERO_RESET      8'h00
`define TEST_WORD_RESET     16'h0000

// Filter output scaling (coefficients sum to 128)
`define FIR_SHIFT           7

`endif

// [dac_gate_pkg.sv]
// Types shared by the converter datapath gate and checker
package dac_gate_pkg;

	// Transmit gate configuration register layout
	typedef struct packed {
		logic       out_pass;
		logic       in_pass;
		logic [1:0] rsvd;
		logic       osc_rst_pin;
		logic       out_pin;
		logic       in_pin;
		logic       fsc_pin;
	} tx_gate_t;

	// One datapath sample
	typedef struct packed {
		logic        valid;
		logic [15:0] data;
	} sample_t;

	// Serial-port transaction phase, Gray coded
	typedef enum logic [1:0] {
		SPI_IDLE  = 2'h0,
		SPI_INSTR = 2'h1,
		SPI_DATA  = 2'h3,
		SPI_DONE  = 2'h2
	} spi_state_t;

endpackage : dac_gate_pkg

// [dac_datapath_gate_and_prbs_check.sv]
// Converter datapath gate, roll-off filter and sequence checker
//
// Summary of operation
// - Test-word enable set feeds the datapath from the constant word.
// - Constant word is 16-bit two's complement, high and low byte, resets zero.
// - Lane samples reach the converter only while test-word enable is clear.
// - Test-word enable may change at any time without a reset.
// - Seven-tap roll-off filter in output path, enable bit, off after reset.
// - Any link fault flag replaces converter samples by zeros.
// - Gate bit 7 clear zeros converter data, set lets it pass.
// - Gate bit 6 clear zeros datapath input, set lets samples enter.
// - Gate bit 3 picks register write or enable pin as oscillator reset.
// - Oscillator reset only happens when hop mode field says discontinuous.
// - Gate bit 2 picks register bit 7 or enable pin for output zeroing.
// - Gate bit 1 picks register bit 6 or enable pin for input zeroing.
// - Gate bit 0 set lets the enable pin ramp full-scale current down.
// - Input zeros pass the filter; bypassed path drops to zero at once.
// - Checker uses 7-stage pattern for select 0, 15-stage for select 1.
// - Control 0b11 holds checker in reset, 0b01 runs it; host then waits.
// - Control bits 6 and 7 read 0 when I or Q channel saw errors.
// - Separate readable error counters for I and Q channels.
// - Checker takes 32-bit groups, compares to previous, one error per group.
// - I and Q fail are interrupt events with enable and status bits.
// - Test-word mode produces samples with no serial link present.
// - Interrupt pin pulled low while any latched source is high.
// - Writing 1 to a status bit clears its latched source.
`include "dac_gate_regs.svh"

module dac_datapath_gate_and_prbs_check
	import dac_gate_pkg::*;
(
	// Clock, reset, enable
	input  wire logic        REF_CLK_I,
	input  wire logic        ARST_N_I,
	input  wire logic        CE_I,
	// Serial register port
	input  wire logic        SPI_CS_N_I,
	input  wire logic        SPI_SCLK_I,
	input  wire logic        SPI_SDI_I,
	output logic             SPI_SDO_O,
	output logic             SPI_SDO_OE_N_O,
	// Lane samples and link health
	input  wire logic        LANE_VALID_I,
	input  wire logic [15:0] LANE_I_I,
	input  wire logic [15:0] LANE_Q_I,
	input  wire logic        LINK_FAULT_I,
	// Transmit enable pin
	input  wire logic        TX_ENABLE_I,
	// Converter decoder side
	output logic             DAC_VALID_O,
	output logic [15:0]      DAC_DATA_O,
	output logic             FSC_MIN_O,
	output logic             TONE_OSC_RESET_O,
	// Open-drain interrupt pin
	input  wire logic        IRQ_I,
	output logic             IRQ_O,
	output logic             IRQ_OE_N_O
);

	////////////////////////////////////////////////////////////////////////
	// Functions

	// Roll-off compensation taps, symmetric
	function automatic logic signed [8:0] coef(input int k);
		case (k)
			0, 6:    coef = 9'h1ff;
			1, 5:    coef = 9'h003;
			2, 4:    coef = 9'h1f6;
			default: coef = 9'h090;
		endcase
	endfunction : coef

	// Clamp a scaled sum to 16 bits
	function automatic logic [15:0] sat16(input logic signed [26:0] v);
		if (v > 27'sh0007fff)
			sat16 = 16'h7fff;
		else if (v < -27'sh0008000)
			sat16 = 16'h8000;
		else
			sat16 = v[15:0];
	endfunction : sat16

	// Any mismatch in a 32-bit group against the pattern recurrence
	function automatic logic group_err(input logic [31:0] prev,
		input logic [31:0] cur, input logic long_seq);
		logic [63:0] w;
		logic        e;
		w = {prev, cur};
		e = 1'b0;
		for (int j = 0; j < 32; j++) begin
			if (long_seq)
				e = e | (w[j] ^ w[j+14] ^ w[j+15]);
			else
				e = e | (w[j] ^ w[j+6] ^ w[j+7]);
		end
		return e;
	endfunction : group_err

	////////////////////////////////////////////////////////////////////////
	// Declarations

	logic             cs_m, cs_s, sck_m, sck_s, sck_d, sdi_m, sdi_s;
	logic             tx_m, tx_s, tx_d;
	logic             sck_rise, sck_fall, tx_rise;
	spi_state_t       spi_state;
	logic [4:0]       bit_cnt;
	logic [15:0]      instr;
	logic [7:0]       wdat, rd_sh;
	logic             wr_pulse;
	logic [14:0]      wr_addr;
	logic [7:0]       wr_data;
	logic [7:0]       next_rd;
	tx_gate_t         gate;
	logic [3:0]       upsample_ratio_select;
	logic             rolloff_comp_enable;
	logic             const_word_source_enable;
	logic [15:0]      test_word;
	logic [7:0]       hop_ctrl;
	logic [2:0]       chk_ctrl;
	logic [1:0]       irq_en, irq_src, fail_d;
	logic [7:0]       cnt_i, cnt_q;
	logic [15:0]      half_i, half_q;
	logic             half_full, prev_ok;
	logic [31:0]      prev_i, prev_q;
	logic             in_allow, out_allow;
	sample_t          s0, s1;
	logic [15:0]      taps [0:6];
	logic signed [26:0] acc;
	logic [1:0]       fail;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	// Two stages, third stage only for edge finding
	always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			{cs_m, cs_s} <= 2'h3;
			{sck_m, sck_s, sck_d} <= 3'h0;
			{sdi_m, sdi_s} <= 2'h0;
			{tx_m, tx_s, tx_d} <= 3'h0;
		end else if (CE_I) begin
			cs_m  <= SPI_CS_N_I;
			cs_s  <= cs_m;
			sck_m <= SPI_SCLK_I;
			sck_s <= sck_m;
			sck_d <= sck_s;
			sdi_m <= SPI_SDI_I;
			sdi_s <= sdi_m;
			tx_m  <= TX_ENABLE_I;
			tx_s  <= tx_m;
			tx_d  <= tx_s;
		end
	end

	assign sck_rise = sck_s & ~sck_d;
	assign sck_fall = ~sck_s & sck_d;
	assign tx_rise  = tx_s & ~tx_d;

	////////////////////////////////////////////////////////////////////////
	// Serial register port: 16-bit instruction, then one data byte

	always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			spi_state      <= SPI_IDLE;
			bit_cnt        <= 5'h00;
			instr          <= 16'h0000;
			wdat           <= 8'h00;
			rd_sh          <= 8'h00;
			wr_pulse       <= 1'b0;
			wr_addr        <= 15'h0000;
			wr_data        <= 8'h00;
			SPI_SDO_O      <= 1'b0;
			SPI_SDO_OE_N_O <= 1'b1;
		end else if (CE_I) begin
			wr_pulse <= 1'b0;
			if (cs_s) begin
				spi_state      <= SPI_IDLE;
				bit_cnt        <= 5'h00;
				SPI_SDO_OE_N_O <= 1'b1;
			end else begin
				case (spi_state)
					SPI_IDLE: spi_state <= SPI_INSTR;
					SPI_INSTR: if (sck_rise) begin
						instr   <= {instr[14:0], sdi_s};
						bit_cnt <= bit_cnt + 5'h01;
						if (bit_cnt == 5'h0f) begin
							spi_state <= SPI_DATA;
							bit_cnt   <= 5'h00;
							rd_sh     <= next_rd;
						end
					end
					SPI_DATA: begin
						if (sck_rise) begin
							wdat    <= {wdat[6:0], sdi_s};
							bit_cnt <= bit_cnt + 5'h01;
							if (bit_cnt == 5'h07) begin
								spi_state <= SPI_DONE;
								wr_pulse  <= ~instr[15];
								wr_addr   <= instr[14:0];
								wr_data   <= {wdat[6:0], sdi_s};
							end
						end
						if (sck_fall && instr[15]) begin
							SPI_SDO_O      <= rd_sh[7];
							SPI_SDO_OE_N_O <= 1'b0;
							rd_sh          <= {rd_sh[6:0], 1'b0};
						end
					end
					SPI_DONE: if (sck_fall) SPI_SDO_OE_N_O <= 1'b1;
					default: spi_state <= SPI_IDLE;
				endcase
			end
		end
	end

	// Read data for the address that the instruction just completed
	always_comb begin
		logic [14:0] a;
		a = {instr[13:0], sdi_s};
		next_rd = 8'h00;
		case (a)
			`REG_IRQ_ENABLE:     next_rd = {6'h00, irq_en};
			`REG_IRQ_STATUS:     next_rd = {6'h00,
				(irq_en & irq_src) | (~irq_en & fail)};
			`REG_TX_GATE:        next_rd = gate;
			`REG_UPSAMPLE:       next_rd = {4'h0, upsample_ratio_select};
			`REG_DATAPATH_CFG:   next_rd = {rolloff_comp_enable, 7'h00};
			`REG_CHECKER_CTRL:   next_rd = {cnt_q == 8'h00,
				cnt_i == 8'h00, 3'h0, chk_ctrl};
			`REG_CHECKER_CNT_I:  next_rd = cnt_i;
			`REG_CHECKER_CNT_Q:  next_rd = cnt_q;
			`REG_TEST_WORD_HIGH: next_rd = test_word[15:8];
			`REG_TEST_WORD_LOW:  next_rd = test_word[7:0];
			`REG_CONST_CFG:      next_rd = {6'h00, const_word_source_enable,
				1'b0};
			`REG_HOP_CTRL:       next_rd = hop_ctrl;
			default:             next_rd = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Control registers

	// Register writes, taken at any time
	always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			gate                     <= tx_gate_t'(`TX_GATE_RESET);
			upsample_ratio_select    <= `UPSAMPLE_BYPASS;
			rolloff_comp_enable      <= 1'b0;
			const_word_source_enable <= 1'b0;
			test_word                <= `TEST_WORD_RESET;
			hop_ctrl                 <= `REG_ZERO_RESET;
			chk_ctrl                 <= 3'h0;
			irq_en                   <= 2'h0;
		end else if (CE_I && wr_pulse) begin
			case (wr_addr)
				`REG_TX_GATE: begin
					gate      <= tx_gate_t'(wr_data);
					gate.rsvd <= 2'h0;
				end
				`REG_UPSAMPLE:       upsample_ratio_select <= wr_data[3:0];
				`REG_DATAPATH_CFG:
					rolloff_comp_enable <= wr_data[`ROLLOFF_EN_BIT];
				`REG_CONST_CFG:
					const_word_source_enable <= wr_data[`CONST_EN_BIT];
				`REG_TEST_WORD_HIGH: test_word[15:8] <= wr_data;
				`REG_TEST_WORD_LOW:  test_word[7:0] <= wr_data;
				`REG_HOP_CTRL:       hop_ctrl <= wr_data;
				`REG_CHECKER_CTRL:   chk_ctrl <= wr_data[2:0];
				`REG_IRQ_ENABLE:     irq_en <= wr_data[1:0];
				default: ;
			endcase
		end
	end

	// Zeroing controls from register or pin
	assign in_allow  = gate.in_pin ? tx_s : gate.in_pass;
	assign out_allow = gate.out_pin ? tx_s : gate.out_pass;

	////////////////////////////////////////////////////////////////////////
	// Datapath input: source select and input zeroing

	always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			s0 <= '0;
		end else if (CE_I) begin
			// Constant word runs every cycle, no link needed
			s0.valid <= const_word_source_enable | LANE_VALID_I;
			if (!in_allow)
				s0.data <= 16'h0000;
			else if (const_word_source_enable)
				s0.data <= test_word;
			else
				s0.data <= LANE_I_I;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Roll-off compensation filter

	// Tap line advances once per sample
	always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			for (int k = 0; k < 7; k++)
				taps[k] <= 16'h0000;
		end else if (CE_I && s0.valid) begin
			taps[0] <= s0.data;
			for (int k = 1; k < 7; k++)
				taps[k] <= taps[k-1];
		end
	end

	// Weighted sum of the current sample and six older ones
	always_comb begin
		acc = 27'sd0;
		for (int k = 0; k < 7; k++) begin
			if (k == 0)
				acc = acc + 27'(coef(k) * $signed(s0.data));
			else
				acc = acc + 27'(coef(k) * $signed(taps[k-1]));
		end
	end

	always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			s1 <= '0;
		end else if (CE_I) begin
			s1.valid <= s0.valid;
			if (s0.valid && rolloff_comp_enable)
				s1.data <= sat16(acc >>> `FIR_SHIFT);
			else if (s0.valid)
				s1.data <= s0.data;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output blanking toward the converter decoder

	always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			DAC_VALID_O <= 1'b0;
			DAC_DATA_O  <= 16'h0000;
		end else if (CE_I) begin
			DAC_VALID_O <= s1.valid;
			if (s1.valid) begin
				if (LINK_FAULT_I || !out_allow)
					DAC_DATA_O <= 16'h0000;
				else
					DAC_DATA_O <= s1.data;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Full-scale current and oscillator reset

	always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			FSC_MIN_O        <= 1'b0;
			TONE_OSC_RESET_O <= 1'b0;
		end else if (CE_I) begin
			FSC_MIN_O <= gate.fsc_pin & ~tx_s;
			TONE_OSC_RESET_O <= (hop_ctrl[`HOP_MODE_MSB:`HOP_MODE_LSB] ==
				`HOP_MODE_DISCONT) &&
				(gate.osc_rst_pin ? tx_rise :
				(wr_pulse && wr_addr == `REG_HOP_CTRL));
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sequence checker on received lane samples

	always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			half_i    <= 16'h0000;
			half_q    <= 16'h0000;
			half_full <= 1'b0;
			prev_ok   <= 1'b0;
			prev_i    <= 32'h0;
			prev_q    <= 32'h0;
			cnt_i     <= 8'h00;
			cnt_q     <= 8'h00;
		end else if (CE_I) begin
			if (chk_ctrl[`CHK_RST_BIT]) begin
				half_full <= 1'b0;
				prev_ok   <= 1'b0;
				cnt_i     <= 8'h00;
				cnt_q     <= 8'h00;
			end else if (chk_ctrl[`CHK_EN_BIT] && LANE_VALID_I) begin
				half_full <= ~half_full;
				if (!half_full) begin
					half_i <= LANE_I_I;
					half_q <= LANE_Q_I;
				end else begin
					prev_i  <= {half_i, LANE_I_I};
					prev_q  <= {half_q, LANE_Q_I};
					prev_ok <= 1'b1;
					if (prev_ok && cnt_i != 8'hff &&
						group_err(prev_i, {half_i, LANE_I_I},
						chk_ctrl[`CHK_SEL_BIT]))
						cnt_i <= cnt_i + 8'h01;
					if (prev_ok && cnt_q != 8'hff &&
						group_err(prev_q, {half_q, LANE_Q_I},
						chk_ctrl[`CHK_SEL_BIT]))
						cnt_q <= cnt_q + 8'h01;
				end
			end
		end
	end

	assign fail = {cnt_q != 8'h00, cnt_i != 8'h00};

	////////////////////////////////////////////////////////////////////////
	// Checker interrupt sources and open-drain pin

	always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			fail_d     <= 2'h0;
			irq_src    <= 2'h0;
			IRQ_O      <= 1'b0;
			IRQ_OE_N_O <= 1'b1;
		end else if (CE_I) begin
			fail_d <= fail;
			for (int b = 0; b < 2; b++) begin
				if (!irq_en[b])
					irq_src[b] <= 1'b0;
				else if (fail[b] && !fail_d[b])
					irq_src[b] <= 1'b1;
				else if (wr_pulse && wr_addr == `REG_IRQ_STATUS &&
					wr_data[b])
					irq_src[b] <= 1'b0;
			end
			IRQ_O      <= 1'b0;
			IRQ_OE_N_O <= ~|irq_src;
		end
	end

endmodule : dac_datapath_gate_and_prbs_check

// [dac_gate_chk_sva.sv]
// Port checker for the converter datapath gate
module dac_gate_chk (
	// Clock and reset
	input wire logic        REF_CLK_I,
	input wire logic        ARST_N_I,
	// Watched ports
	input wire logic        SPI_CS_N_I,
	input wire logic        SPI_SDO_OE_N_O,
	input wire logic        LANE_VALID_I,
	input wire logic        LINK_FAULT_I,
	input wire logic        TX_ENABLE_I,
	input wire logic        DAC_VALID_O,
	input wire logic [15:0] DAC_DATA_O,
	input wire logic        FSC_MIN_O,
	input wire logic        TONE_OSC_RESET_O,
	input wire logic        IRQ_O,
	input wire logic        IRQ_OE_N_O
);
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (!ARST_N_I);

	// Datapath timing and blanking
	AST_LANE_LAT: assert property (LANE_VALID_I |-> ##3 DAC_VALID_O)
		else $error("lane sample lost in datapath");
	AST_FAULT_ZERO: assert property (
		LINK_FAULT_I ##1 DAC_VALID_O |-> DAC_DATA_O == 16'h0000)
		else $error("faulted sample reached converter");
	AST_DATA_HOLD: assert property (!DAC_VALID_O |-> $stable(DAC_DATA_O))
		else $error("converter data moved without valid");
	// Pin functions
	AST_OSC_PULSE: assert property (TONE_OSC_RESET_O |=> !TONE_OSC_RESET_O)
		else $error("oscillator reset longer than one cycle");
	AST_FSC_PIN: assert property (TX_ENABLE_I [*4] |-> !FSC_MIN_O)
		else $error("current ramp with pin high");
	AST_IRQ_DRAIN: assert property (IRQ_O == 1'b0)
		else $error("interrupt pin driven high");
	AST_SDO_FREE: assert property (SPI_CS_N_I [*5] |-> SPI_SDO_OE_N_O)
		else $error("read data driven while deselected");
	AST_RST_QUIET: assert property ($rose(ARST_N_I) |->
		IRQ_OE_N_O && !DAC_VALID_O && !TONE_OSC_RESET_O)
		else $error("outputs active after reset");
endmodule : dac_gate_chk

bind dac_datapath_gate_and_prbs_check dac_gate_chk dac_gate_chk_inst (
	.REF_CLK_I(REF_CLK_I), .ARST_N_I(ARST_N_I), .SPI_CS_N_I(SPI_CS_N_I),
	.SPI_SDO_OE_N_O(SPI_SDO_OE_N_O), .LANE_VALID_I(LANE_VALID_I),
	.LINK_FAULT_I(LINK_FAULT_I), .TX_ENABLE_I(TX_ENABLE_I),
	.DAC_VALID_O(DAC_VALID_O), .DAC_DATA_O(DAC_DATA_O),
	.FSC_MIN_O(FSC_MIN_O), .TONE_OSC_RESET_O(TONE_OSC_RESET_O),
	.IRQ_O(IRQ_O), .IRQ_OE_N_O(IRQ_OE_N_O)
);

// [lane_src.sv]
// Lane sample source in place of the link transmitter
module lane_src (
	// Clock
	input  wire logic   clk_i,
	// Lane samples
	output logic        valid_o,
	output logic [15:0] i_o,
	output logic [15:0] q_o
);
	timeunit 1ns;
	timeprecision 1ns;

	// Idle lines
	initial begin
		valid_o = 1'b0;
		i_o = 16'h0000;
		q_o = 16'h0000;
	end

	// One sample, then stale lines are inverted
	task automatic send(input logic [15:0] di, input logic [15:0] dq);
		@(posedge clk_i);
		valid_o <= 1'b1;
		i_o <= di;
		q_o <= dq;
		@(posedge clk_i);
		valid_o <= 1'b0;
		i_o <= ~di;
		q_o <= ~dq;
	endtask : send
endmodule : lane_src

// [dac_datapath_gate_and_prbs_check_tb.sv]
// Self-checking bench for the datapath gate and checker
`include "dac_gate_regs.svh"

module dac_datapath_gate_and_prbs_check_tb;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clk, rst_n, cs_n, sclk, sdi, tx_en, fault, lv;
	logic        sdo, dv, fsc, osc, irq, irq_oe_n, irq_pin, sdo_oe_n;
	logic [15:0] li, lq, dd, e;
	logic [7:0]  rv;
	int          bad_count, checks, osc_cnt, k;
	logic [7:0]  gv [7] = '{8'hc0, 8'h40, 8'h80, 8'hc4, 8'hc4, 8'hc2, 8'hc2};
	logic        pv [7] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
	logic        ev [7] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};

	// Pulled-up open-drain interrupt wire
	assign irq_pin = irq_oe_n ? 1'b1 : irq;

	dac_datapath_gate_and_prbs_check dac_datapath_gate_and_prbs_check_inst (
		.REF_CLK_I(clk), .ARST_N_I(rst_n), .CE_I(1'b1),
		.SPI_CS_N_I(cs_n), .SPI_SCLK_I(sclk), .SPI_SDI_I(sdi),
		.SPI_SDO_O(sdo), .SPI_SDO_OE_N_O(sdo_oe_n),
		.LANE_VALID_I(lv), .LANE_I_I(li), .LANE_Q_I(lq),
		.LINK_FAULT_I(fault), .TX_ENABLE_I(tx_en),
		.DAC_VALID_O(dv), .DAC_DATA_O(dd), .FSC_MIN_O(fsc),
		.TONE_OSC_RESET_O(osc), .IRQ_I(irq_pin), .IRQ_O(irq),
		.IRQ_OE_N_O(irq_oe_n)
	);
	lane_src lane_src_inst (.clk_i(clk), .valid_o(lv), .i_o(li), .q_o(lq));

	// Clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Oscillator reset pulse counter
	always @(posedge clk) begin
		if (osc === 1'b1) osc_cnt++;
	end

	////////////////////////////////////////////////////////////////////////
	// Compare and report
	task automatic cmp_reg(input string n, input logic [7:0] x, input logic [7:0] g);
		checks++;
		if (g !== x) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", n, x, g);
		end
	endtask : cmp_reg
	task automatic cmp_smp(input string n, input logic [15:0] x, input logic [15:0] g);
		checks++;
		if (g !== x) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", n, x, g);
		end
	endtask : cmp_smp
	task automatic cmp_bit(input string n, input logic x, input logic g);
		checks++;
		if (g !== x) begin
			bad_count++;
			$display("mismatch %s expected %b seen %b", n, x, g);
		end
	endtask : cmp_bit
	task automatic report_and_stop;
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : report_and_stop

	////////////////////////////////////////////////////////////////////////
	// Serial register frame: one byte, MSB first, read data into rv
	task automatic spi(input logic r, input logic [14:0] a, input logic [7:0] w);
		logic [23:0] sh;
		sh = {r, a, w};
		rv = 8'h00;
		@(posedge clk);
		cs_n <= 1'b0;
		for (int i = 23; i >= 0; i--) begin
			sdi <= sh[i];
			repeat (5) @(posedge clk);
			sclk <= 1'b1;
			// Read data only counts while the driver is enabled
			if (i < 8) rv[i] = (sdo_oe_n === 1'b0) ? sdo : 1'bx;
			repeat (5) @(posedge clk);
			sclk <= 1'b0;
		end
		repeat (8) @(posedge clk);
		cs_n <= 1'b1;
		repeat (6) @(posedge clk);
	endtask : spi
	task automatic wr(input logic [14:0] a, input logic [7:0] w);
		spi(1'b0, a, w);
	endtask : wr
	task automatic rd_chk(input string n, input logic [14:0] a, input logic [7:0] x);
		spi(1'b1, a, 8'h00);
		cmp_reg(n, x, rv);
	endtask : rd_chk
	// One lane sample (Q is its inverse), wait for converter valid
	task automatic get(input logic [15:0] d);
		int n;
		lane_src_inst.send(d, ~d);
		n = 0;
		while (dv !== 1'b1) begin
			@(negedge clk);
			n++;
			if (n > 8) begin
				bad_count++;
				report_and_stop();
			end
		end
		// Hand back on a rising edge so later drives stay edge-aligned
		@(posedge clk);
	endtask : get

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		bad_count = 0;
		checks = 0;
		osc_cnt = 0;
		rst_n = 1'b0;
		cs_n = 1'b1;
		sclk = 1'b0;
		sdi = 1'b0;
		tx_en = 1'b0;
		fault = 1'b0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		// Reset values and an unmapped place
		rd_chk("gate_rst", `REG_TX_GATE, `TX_GATE_RESET);
		rd_chk("word_rst", `REG_TEST_WORD_LOW, 8'h00);
		rd_chk("fir_rst", `REG_DATAPATH_CFG, 8'h00);
		wr(15'h7123, 8'h5a);
		rd_chk("unmapped", 15'h7123, 8'h00);
		// Gate settings by register and by pin
		for (k = 0; k < 7; k++) begin
			tx_en <= pv[k];
			wr(`REG_TX_GATE, gv[k]);
			get(16'h1357);
			e = ev[k] ? 16'h1357 : 16'h0000;
			cmp_smp("gate", e, dd);
		end
		wr(`REG_TX_GATE, 8'hc0);
		fault <= 1'b1;
		get(16'h2468);
		cmp_smp("fault", 16'h0000, dd);
		fault <= 1'b0;
		// Roll-off filter: impulse is reshaped, flat input passes
		wr(`REG_DATAPATH_CFG, 8'h80);
		for (k = 0; k < 7; k++) get(16'h0000);
		get(16'h0400);
		cmp_bit("fir_on", 1'b1, dd !== 16'h0400);
		for (k = 0; k < 7; k++) get(16'h0400);
		cmp_smp("fir_flat", 16'h0400, dd);
		wr(`REG_DATAPATH_CFG, 8'h00);
		// Constant word replaces lane data, then lanes return
		wr(`REG_UPSAMPLE, {4'h0, `UPSAMPLE_BYPASS});
		wr(`REG_TEST_WORD_HIGH, 8'h81);
		wr(`REG_TEST_WORD_LOW, 8'h7e);
		rd_chk("word_hi", `REG_TEST_WORD_HIGH, 8'h81);
		wr(`REG_CONST_CFG, 8'h02);
		get(16'h5555);
		repeat (4) @(negedge clk);
		cmp_smp("const", 16'h817e, dd);
		wr(`REG_CONST_CFG, 8'h00);
		get(16'h2222);
		cmp_smp("lane_back", 16'h2222, dd);
		// Oscillator reset by write, then by pin
		wr(`REG_HOP_CTRL, 8'h40);
		wr(`REG_HOP_CTRL, 8'h40);
		cmp_reg("osc_spi", 8'h01, 8'(osc_cnt));
		tx_en <= 1'b0;
		wr(`REG_TX_GATE, 8'hc8);
		tx_en <= 1'b1;
		repeat (8) @(negedge clk);
		wr(`REG_HOP_CTRL, 8'h00);
		cmp_reg("osc_pin", 8'h02, 8'(osc_cnt));
		tx_en <= 1'b0;
		repeat (8) @(negedge clk);
		@(posedge clk);
		tx_en <= 1'b1;
		repeat (8) @(negedge clk);
		cmp_reg("osc_mode", 8'h02, 8'(osc_cnt));
		// Full-scale current by pin
		wr(`REG_TX_GATE, 8'hc1);
		tx_en <= 1'b0;
		repeat (6) @(negedge clk);
		cmp_bit("fsc_pin_low", 1'b1, fsc);
		@(posedge clk);
		tx_en <= 1'b1;
		repeat (6) @(negedge clk);
		cmp_bit("fsc_pin_high", 1'b0, fsc);
		wr(`REG_TX_GATE, 8'hc0);
		tx_en <= 1'b0;
		repeat (6) @(negedge clk);
		cmp_bit("fsc_reg", 1'b0, fsc);
		// Short pattern: I clean, Q all ones fails
		wr(`REG_IRQ_ENABLE, 8'h03);
		wr(`REG_CHECKER_CTRL, 8'h03);
		wr(`REG_CHECKER_CTRL, 8'h01);
		for (k = 0; k < 8; k++) get(16'h0000);
		repeat (4) @(negedge clk);
		cmp_bit("irq_q", 1'b0, irq_pin);
		spi(1'b1, `REG_CHECKER_CTRL, 8'h00);
		cmp_reg("flags7", 8'h41, rv & 8'hc7);
		rd_chk("err_i", `REG_CHECKER_CNT_I, 8'h00);
		rd_chk("err_q", `REG_CHECKER_CNT_Q, 8'h03);
		rd_chk("stat_q", `REG_IRQ_STATUS, 8'h02);
		wr(`REG_IRQ_STATUS, 8'h02);
		cmp_bit("irq_clr", 1'b1, irq_pin);
		// Long pattern: roles swapped
		wr(`REG_CHECKER_CTRL, 8'h07);
		wr(`REG_CHECKER_CTRL, 8'h05);
		for (k = 0; k < 8; k++) get(16'hffff);
		spi(1'b1, `REG_CHECKER_CTRL, 8'h00);
		cmp_reg("flags15", 8'h85, rv & 8'hc7);
		rd_chk("err_i15", `REG_CHECKER_CNT_I, 8'h03);
		rd_chk("stat_i", `REG_IRQ_STATUS, 8'h01);
		report_and_stop();
	end
endmodule : dac_datapath_gate_and_prbs_check_tb
